/* hw/fwsm_top.sv */
`timescale 1ns/1ns
`include "fwsm_regs.svh"
// Notes on behaviour
// - Over-temperature shutdown sets shutdown flag, bit 0 of fault status two.
// - While the shutdown condition is present, class-D outputs go high impedance.
// - Shutdown fault is reported on the fault pin unless masked.
// - Over-temperature recovers by itself once the condition disappears.
// - Shutdown flag holds until software writes one to clear bit 7.
// - Cycle current faults: right at bit 2, left at bit 1, reset 0.
// - Cycle current warnings: left at bit 5, right at bit 4, reset 0.
// - Temperature warning bit 0 at 112C, bit 1 at 122C.
// - Temperature warning bit 2 at 134C, bit 3 at 146C.
// - Mask bit 7 suppresses shutdown reports on the fault pin.
// - Mask bit 6 suppresses logic supply low, bit 5 logic supply high.
// - Mask bit 4 suppresses clock fault reports.
// - Mask bit 2 suppresses power supply low and high reports.
// - Mask bit 1 suppresses output DC fault reports.
// - Mask bit 0 suppresses output over-current reports.
// - Writing one to clear bit 7 clears latched analog fault flags.
module fwsm_top #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Protection detectors and neighbouring fault flags
	input  wire fwsm_pkg::fwsm_det_t  det,
	input  wire fwsm_pkg::fwsm_ext_t  ext_flags,
	// Device side outputs
	output logic                      fault_pin,
	output logic                      class_d_hiz,
	output logic                      analog_fault_clear,
	output logic                      irq
);
	import fwsm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [7:0]            fault_status_two;
	logic [7:0]            warning_status;
	logic [7:0]            fault_pin_report_mask;
	logic [`FWSM_IRQ_W-1:0] irq_status;
	logic [`FWSM_IRQ_W-1:0] irq_mask;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	wire [ADDR_W-3:0] word_idx   = paddr[ADDR_W-1:2];
	wire              acc_phase  = psel & penable;
	wire              acc_done   = acc_phase & pready;
	wire              wr_go      = acc_done & pwrite & pstrb[0];
	wire              hit_fault2 = (word_idx == (ADDR_W-2)'(`FWSM_IDX_FAULT2));
	wire              hit_warn   = (word_idx == (ADDR_W-2)'(`FWSM_IDX_WARN));
	wire              hit_mask   = (word_idx == (ADDR_W-2)'(`FWSM_IDX_PINMASK));
	wire              hit_clear  = (word_idx == (ADDR_W-2)'(`FWSM_IDX_CLEAR));
	wire              hit_istat  = (word_idx == (ADDR_W-2)'(`FWSM_IDX_IRQ_STAT));
	wire              hit_imask  = (word_idx == (ADDR_W-2)'(`FWSM_IDX_IRQ_MASK));
	wire              hit_any    = hit_fault2 | hit_warn | hit_mask |
	                               hit_clear | hit_istat | hit_imask;

	// Write strobes per register
	wire wr_mask  = wr_go & hit_mask;
	wire wr_istat = wr_go & hit_istat;
	wire wr_imask = wr_go & hit_imask;
	wire clr_go   = wr_go & hit_clear & pwdata[`FWSM_CLR_ANALOG];

	// Read mux; clear register reads as zero since its bit is write-only
	wire [7:0] rd_byte = hit_fault2 ? fault_status_two :
	                     hit_warn   ? warning_status :
	                     hit_mask   ? fault_pin_report_mask :
	                     hit_istat  ? {4'h0, irq_status} :
	                     hit_imask  ? {4'h0, irq_mask} :
	                     `FWSM_RST_BYTE;

	////////////////////////////////////////////////////////////////////////
	// Sticky flag update; a detector level in the clear cycle wins

	wire [7:0] set_fault2;
	wire [7:0] set_warn;
	assign set_fault2[`FWSM_F2_SHUTDOWN]  = det.over_temp_shutdown;
	assign set_fault2[`FWSM_F2_LEFT_CUR]  = det.left_cycle_current_limit;
	assign set_fault2[`FWSM_F2_RIGHT_CUR] = det.right_cycle_current_limit;
	assign set_fault2[7:3]                = 5'h00;
	assign set_warn[`FWSM_WN_TEMP_HI:`FWSM_WN_TEMP_LO] = det.over_temp_warning;
	assign set_warn[`FWSM_WN_RIGHT_CUR]   = det.right_cycle_current_warn;
	assign set_warn[`FWSM_WN_LEFT_CUR]    = det.left_cycle_current_warn;
	assign set_warn[7:6]                  = 2'h0;

	// Only the clear write removes a flag
	wire [7:0] next_fault2 = (clr_go ? `FWSM_RST_BYTE : fault_status_two) | set_fault2;
	wire [7:0] next_warn   = (clr_go ? `FWSM_RST_BYTE : warning_status) | set_warn;

	////////////////////////////////////////////////////////////////////////
	// Interrupt events: a flag going from clear to set

	wire [`FWSM_IRQ_W-1:0] irq_event;
	assign irq_event[`FWSM_IRQ_SHUTDOWN]  = |(set_fault2[`FWSM_F2_SHUTDOWN] &
	                                          ~fault_status_two[`FWSM_F2_SHUTDOWN]);
	assign irq_event[`FWSM_IRQ_CUR_FAULT] =
		|(set_fault2[`FWSM_F2_RIGHT_CUR:`FWSM_F2_LEFT_CUR] &
		  ~fault_status_two[`FWSM_F2_RIGHT_CUR:`FWSM_F2_LEFT_CUR]);
	assign irq_event[`FWSM_IRQ_CUR_WARN]  =
		|(set_warn[`FWSM_WN_LEFT_CUR:`FWSM_WN_RIGHT_CUR] &
		  ~warning_status[`FWSM_WN_LEFT_CUR:`FWSM_WN_RIGHT_CUR]);
	assign irq_event[`FWSM_IRQ_TEMP_WARN] =
		|(set_warn[`FWSM_WN_TEMP_HI:`FWSM_WN_TEMP_LO] &
		  ~warning_status[`FWSM_WN_TEMP_HI:`FWSM_WN_TEMP_LO]);

	// Write one to clear, but a new event in the same cycle survives
	wire [`FWSM_IRQ_W-1:0] next_irq_status =
		(irq_status & ~(wr_istat ? pwdata[`FWSM_IRQ_W-1:0] : `FWSM_RST_IRQ)) | irq_event;
	wire next_irq = |(next_irq_status & ~irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Fault pin report: each source gated by its mask bit

	wire [7:0] m = fault_pin_report_mask;
	wire rep_shut = next_fault2[`FWSM_F2_SHUTDOWN] & ~m[`FWSM_PM_SHUTDOWN];
	wire rep_dvuv = ext_flags.logic_supply_low & ~m[`FWSM_PM_DVDD_UV];
	wire rep_dvov = ext_flags.logic_supply_high & ~m[`FWSM_PM_DVDD_OV];
	wire rep_clk  = ext_flags.clock_fault & ~m[`FWSM_PM_CLK];
	wire rep_pvdd = (ext_flags.power_supply_low | ext_flags.power_supply_high) &
	                ~m[`FWSM_PM_PVDD];
	wire rep_dc   = ext_flags.output_dc & ~m[`FWSM_PM_DC];
	wire rep_oc   = ext_flags.overcurrent & ~m[`FWSM_PM_OC];
	wire next_fault_pin = rep_shut | rep_dvuv | rep_dvov | rep_clk |
	                      rep_pvdd | rep_dc | rep_oc;

	// Mask write keeps the reserved bit at zero
	wire [7:0] next_mask = wr_mask ? (pwdata[7:0] & `FWSM_PM_WMASK) : m;

	////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, so every access ends on its second
	// access cycle; the read byte is captured as pready rises

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `FWSM_RST_WORD;
		end else begin
			pready  <= acc_phase & ~pready;
			pslverr <= acc_phase & ~pready & ~hit_any;
			if (acc_phase & ~pready & ~pwrite) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags and mask

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_status_two      <= `FWSM_RST_BYTE;
			warning_status        <= `FWSM_RST_BYTE;
			fault_pin_report_mask <= `FWSM_RST_BYTE;
		end else begin
			fault_status_two      <= next_fault2;
			warning_status        <= next_warn;
			fault_pin_report_mask <= next_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= `FWSM_RST_IRQ;
			irq_mask   <= `FWSM_RST_IRQ;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= next_irq;
			if (wr_imask) begin
				irq_mask <= pwdata[`FWSM_IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Device outputs; the power stage follows the live shutdown condition
	// so it returns to its earlier state without software, while the
	// status flag stays latched for software to inspect

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_pin          <= 1'b0;
			class_d_hiz        <= 1'b0;
			analog_fault_clear <= 1'b0;
		end else begin
			fault_pin          <= next_fault_pin;
			class_d_hiz        <= det.over_temp_shutdown;
			analog_fault_clear <= clr_go;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clear_write;
		psel && penable && pready && pwrite && pstrb[0] && hit_clear &&
		pwdata[`FWSM_CLR_ANALOG];
	endsequence

	sequence s_no_new_fault;
		!det.over_temp_shutdown && !det.left_cycle_current_limit &&
		!det.right_cycle_current_limit;
	endsequence

	// Warning detectors all quiet, so the clear must empty the register
	sequence s_no_new_warn;
		det.over_temp_warning == 4'h0 && !det.left_cycle_current_warn &&
		!det.right_cycle_current_warn;
	endsequence

	// An access cycle still waiting on its one wait state
	sequence s_wait_state;
		psel && penable && !pready;
	endsequence

	a_shutdown_sets: assert property (det.over_temp_shutdown |=>
		fault_status_two[`FWSM_F2_SHUTDOWN])
		else $error("Shutdown flag not set");

	a_hiz_shutdown: assert property (det.over_temp_shutdown |=> class_d_hiz)
		else $error("Outputs not high impedance during shutdown");

	a_shutdown_report: assert property (
		fault_status_two[`FWSM_F2_SHUTDOWN] && !m[`FWSM_PM_SHUTDOWN] && !clr_go |=> fault_pin)
		else $error("Shutdown fault not reported");

	a_auto_recover: assert property (
		!det.over_temp_shutdown [*2] |-> !class_d_hiz)
		else $error("Power stage did not recover");

	a_shutdown_hold: assert property (
		fault_status_two[`FWSM_F2_SHUTDOWN] && !clr_go |=>
		fault_status_two[`FWSM_F2_SHUTDOWN] [*1])
		else $error("Shutdown flag lost without clear");

	a_current_flags: assert property (
		det.right_cycle_current_limit && det.left_cycle_current_limit |=>
		fault_status_two[`FWSM_F2_RIGHT_CUR] && fault_status_two[`FWSM_F2_LEFT_CUR])
		else $error("Cycle current fault flags not set");

	a_current_warns: assert property (
		det.left_cycle_current_warn |=> warning_status[`FWSM_WN_LEFT_CUR])
		else $error("Left cycle current warning not set");

	a_right_warn: assert property (
		det.right_cycle_current_warn |=> warning_status[`FWSM_WN_RIGHT_CUR])
		else $error("Right cycle current warning not set");

	a_temp_levels: assert property (
		1'b1 |=> (warning_status[`FWSM_WN_TEMP_HI:`FWSM_WN_TEMP_LO] &
		$past(det.over_temp_warning)) == $past(det.over_temp_warning))
		else $error("Temperature warning level not latched");

	a_temp_warns: assert property (
		det.over_temp_warning[0] |=> warning_status[`FWSM_WN_TEMP_LO])
		else $error("First temperature warning not set");

	a_temp_upper: assert property (
		det.over_temp_warning[3] |=> warning_status[`FWSM_WN_TEMP_HI])
		else $error("Fourth temperature warning not set");

	a_mask_resv: assert property (!fault_pin_report_mask[`FWSM_PM_RESV])
		else $error("Reserved mask bit set");

	a_clear_flags: assert property (
		s_clear_write ##0 s_no_new_fault |=> fault_status_two == `FWSM_RST_BYTE)
		else $error("Clear write left a flag set");

	a_warn_clear: assert property (
		s_clear_write ##0 s_no_new_warn |=> warning_status == `FWSM_RST_BYTE)
		else $error("Clear write left a warning set");

	a_clear_pulse: assert property (s_clear_write |=> analog_fault_clear)
		else $error("Analog fault clear pulse missing");

	a_clear_single: assert property (!clr_go |=> !analog_fault_clear)
		else $error("Analog fault clear pulse without a clear write");

	a_pin_quiet: assert property (
		!fault_status_two[`FWSM_F2_SHUTDOWN] && !det.over_temp_shutdown &&
		ext_flags == '0 |=> !fault_pin)
		else $error("Fault pin high with no unmasked fault");

	a_mask_shutdown: assert property (
		m[`FWSM_PM_SHUTDOWN] && $stable(m) && ext_flags == '0 |=> !fault_pin)
		else $error("Masked shutdown still reported");

	a_pin_logic: assert property (
		(ext_flags.logic_supply_low && !m[`FWSM_PM_DVDD_UV]) ||
		(ext_flags.logic_supply_high && !m[`FWSM_PM_DVDD_OV]) |=> fault_pin)
		else $error("Logic supply fault not reported");

	a_pin_clock: assert property (
		ext_flags.clock_fault && !m[`FWSM_PM_CLK] |=> fault_pin)
		else $error("Clock fault not reported");

	a_pin_dc: assert property (
		ext_flags.output_dc && !m[`FWSM_PM_DC] |=> fault_pin)
		else $error("Output DC fault not reported");

	a_pin_current: assert property (
		ext_flags.overcurrent && !m[`FWSM_PM_OC] |=> fault_pin)
		else $error("Output over-current fault not reported");

	a_all_masked: assert property (
		m == `FWSM_PM_WMASK |=> !fault_pin)
		else $error("Fault pin high with every report masked");

	a_mask_store: assert property (
		wr_mask |=> m[`FWSM_PM_SHUTDOWN] == $past(pwdata[`FWSM_PM_SHUTDOWN]))
		else $error("Mask write not stored");

	a_pin_supply: assert property (
		ext_flags.power_supply_high && !m[`FWSM_PM_PVDD] |=> fault_pin)
		else $error("Power supply fault not reported");

	a_apb_answer: assert property (s_wait_state |=> pready ##1 !pready)
		else $error("APB answer not after one wait state");

	a_slave_error: assert property (s_wait_state ##0 !hit_any |=> pslverr)
		else $error("Unmapped access without slave error");

	a_irq_sticky: assert property (
		irq_status[`FWSM_IRQ_SHUTDOWN] && !wr_istat |=> irq_status[`FWSM_IRQ_SHUTDOWN])
		else $error("Shutdown interrupt status lost without a write");

endmodule // fwsm_top

/* hw/fwsm_regs.svh */
`ifndef FWSM_REGS_SVH
`define FWSM_REGS_SVH

// Register indices; byte address is four times the index
`define FWSM_IDX_FAULT2        10'h072
`define FWSM_IDX_WARN          10'h073
`define FWSM_IDX_PINMASK       10'h074
`define FWSM_IDX_CLEAR         10'h078
`define FWSM_IDX_IRQ_STAT      10'h079
`define FWSM_IDX_IRQ_MASK      10'h07a

// Field positions, fault status two register
`define FWSM_F2_SHUTDOWN       0
`define FWSM_F2_LEFT_CUR       1
`define FWSM_F2_RIGHT_CUR      2

// Field positions, warning register
`define FWSM_WN_TEMP_LO        0
`define FWSM_WN_TEMP_HI        3
`define FWSM_WN_RIGHT_CUR      4
`define FWSM_WN_LEFT_CUR       5

// Field positions, fault pin mask register
`define FWSM_PM_OC             0
`define FWSM_PM_DC             1
`define FWSM_PM_PVDD           2
`define FWSM_PM_RESV           3
`define FWSM_PM_CLK            4
`define FWSM_PM_DVDD_OV        5
`define FWSM_PM_DVDD_UV        6
`define FWSM_PM_SHUTDOWN       7
`define FWSM_PM_WMASK          8'hf7

// Fault clear register
`define FWSM_CLR_ANALOG        7

// Interrupt status and mask bits
`define FWSM_IRQ_SHUTDOWN      0
`define FWSM_IRQ_CUR_FAULT     1
`define FWSM_IRQ_CUR_WARN      2
`define FWSM_IRQ_TEMP_WARN     3
`define FWSM_IRQ_W             4

// Reset values
`define FWSM_RST_BYTE          8'h00
`define FWSM_RST_IRQ           4'h0
`define FWSM_RST_WORD          32'h0000_0000

`endif

/* hw/fwsm_pkg.sv */
package fwsm_pkg;

	// Live detector levels from the analog protection
	typedef struct packed {
		logic       over_temp_shutdown;
		logic       right_cycle_current_limit;
		logic       left_cycle_current_limit;
		logic       left_cycle_current_warn;
		logic       right_cycle_current_warn;
		logic [3:0] over_temp_warning;
	} fwsm_det_t;

	// Latched fault flags kept by neighbouring fault registers
	typedef struct packed {
		logic logic_supply_low;
		logic logic_supply_high;
		logic clock_fault;
		logic power_supply_low;
		logic power_supply_high;
		logic output_dc;
		logic overcurrent;
	} fwsm_ext_t;

endpackage

/* tb/fwsm_tb_top.sv */
`timescale 1ns/1ns
`include "fwsm_regs.svh"
module fwsm_tb_top;
	import fwsm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Byte addresses are four times the register index
	localparam logic [11:0] A_F2  = 12'(`FWSM_IDX_FAULT2 * 4);
	localparam logic [11:0] A_WN  = 12'(`FWSM_IDX_WARN * 4);
	localparam logic [11:0] A_PM  = 12'(`FWSM_IDX_PINMASK * 4);
	localparam logic [11:0] A_CL  = 12'(`FWSM_IDX_CLEAR * 4);
	localparam logic [11:0] A_IS  = 12'(`FWSM_IDX_IRQ_STAT * 4);
	localparam logic [11:0] A_IM  = 12'(`FWSM_IDX_IRQ_MASK * 4);
	localparam logic [11:0] A_BAD = 12'h3fc;

	// Bench signals; those the bench drives are given a value at time zero
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0000_0000;
	logic [3:0]  pstrb     = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	fwsm_det_t   det       = '0;
	fwsm_ext_t   ext_flags = '0;
	logic        fault_pin;
	logic        class_d_hiz;
	logic        analog_fault_clear;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          n_fail    = 0;
	int          n_checks  = 0;

	// 20 MHz clock
	always #25 pclk = ~pclk;

	fwsm_top #(.ADDR_W(12)) u_fwsm_top (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.pstrb              (pstrb),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.det                (det),
		.ext_flags          (ext_flags),
		.fault_pin          (fault_pin),
		.class_d_hiz        (class_d_hiz),
		.analog_fault_clear (analog_fault_clear),
		.irq                (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic clk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; read data and error are taken at the pready edge only
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			$display("[ERR] pready expected 1 seen 0");
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rdchk(A_F2, 32'h0000_0000, "fault status reset");
		rdchk(A_WN, 32'h0000_0000, "warning reset");
		rdchk(A_PM, 32'h0000_0000, "mask reset");
		chk("fault pin idle", fault_pin, 32'h0);
		chk("hiz idle", class_d_hiz, 32'h0);
		chk("irq idle", irq, 32'h0);
	endtask

	// Reserved mask bit, strobe-less write, read-only places and a hole in the map
	task automatic t_regs();
		apb(1'b1, A_PM, 32'h0000_00ff);
		rdchk(A_PM, 32'h0000_00f7, "mask reserved bit");
		chk("mapped no error", err, 32'h0);
		pstrb <= 4'h0;
		apb(1'b1, A_PM, 32'h0000_0000);
		rdchk(A_PM, 32'h0000_00f7, "mask strobe off");
		pstrb <= 4'hf;
		apb(1'b1, A_PM, 32'h0000_0000);
		apb(1'b1, A_F2, 32'h0000_0007);
		rdchk(A_F2, 32'h0000_0000, "fault status read only");
		apb(1'b1, A_WN, 32'h0000_003f);
		rdchk(A_WN, 32'h0000_0000, "warning read only");
		apb(1'b0, A_BAD, 32'h0000_0000);
		chk("unmapped error", err, 32'h1);
		chk("unmapped data", rd, 32'h0000_0000);
	endtask

	// Shutdown: flag latches while the power stage recovers on its own
	task automatic t_shutdown();
		logic seen;
		seen = 1'b0;
		det.over_temp_shutdown <= 1'b1;
		clk(3);
		chk("hiz during shutdown", class_d_hiz, 32'h1);
		chk("pin on shutdown", fault_pin, 32'h1);
		chk("irq on shutdown", irq, 32'h1);
		det.over_temp_shutdown <= 1'b0;
		clk(3);
		chk("hiz recovered", class_d_hiz, 32'h0);
		rdchk(A_F2, 32'h0000_0001, "shutdown flag held");
		apb(1'b1, A_PM, 32'h0000_0080);
		clk(2);
		chk("pin shutdown masked", fault_pin, 32'h0);
		apb(1'b1, A_PM, 32'h0000_0000);
		apb(1'b1, A_CL, 32'h0000_007f);
		rdchk(A_F2, 32'h0000_0001, "flag after other clear bits");
		apb(1'b1, A_CL, 32'h0000_0080);
		// The pulse lands within a cycle or two of the write edge
		repeat (3) begin
			@(posedge pclk);
			seen = seen | (analog_fault_clear === 1'b1);
		end
		chk("clear pulse", seen, 32'h1);
		rdchk(A_F2, 32'h0000_0000, "shutdown flag cleared");
		chk("pin after clear", fault_pin, 32'h0);
		apb(1'b1, A_IS, 32'h0000_000f);
	endtask

	// Each detector except the shutdown one lands in its own bit and stays until the clear write
	task automatic t_flags();
		logic [31:0] exp_w;
		logic [31:0] exp_f;
		for (int k = 0; k < 8; k++) begin
			exp_w = (k < 6) ? (32'h1 << k) : 32'h0;
			exp_f = (k == 6) ? 32'h2 : ((k == 7) ? 32'h4 : 32'h0);
			det <= 9'(1 << k);
			clk(2);
			det <= '0;
			rdchk(A_F2, exp_f, "fault status bit");
			rdchk(A_WN, exp_w, "warning bit");
			apb(1'b1, A_CL, 32'h0000_0080);
			rdchk(A_WN, 32'h0000_0000, "warning cleared");
		end
	endtask

	// Neighbour faults one at a time, against no mask, their own mask bit and all other mask bits
	task automatic t_pin_mask();
		int mb [7] = '{0, 1, 2, 2, 4, 5, 6};
		for (int i = 0; i < 7; i++) begin
			ext_flags <= 7'(1 << i);
			clk(3);
			chk("pin unmasked fault", fault_pin, 32'h1);
			apb(1'b1, A_PM, 32'h1 << mb[i]);
			clk(2);
			chk("pin own mask", fault_pin, 32'h0);
			apb(1'b1, A_PM, ~(32'h1 << mb[i]) & 32'h0000_00ff);
			clk(2);
			chk("pin other masks", fault_pin, 32'h1);
			apb(1'b1, A_PM, 32'h0000_0000);
		end
		ext_flags <= '0;
		clk(3);
		chk("pin all clear", fault_pin, 32'h0);
	endtask

	// Interrupt raised masked, then unmasked, then cleared by a one
	task automatic t_irq();
		apb(1'b1, A_IS, 32'h0000_000f);
		apb(1'b1, A_IM, 32'h0000_000f);
		det.left_cycle_current_warn <= 1'b1;
		clk(3);
		chk("irq masked", irq, 32'h0);
		rdchk(A_IS, 32'h0000_0004, "warn event status");
		det.left_cycle_current_warn <= 1'b0;
		apb(1'b1, A_IM, 32'h0000_000b);
		clk(2);
		chk("irq unmasked", irq, 32'h1);
		apb(1'b1, A_IS, 32'h0000_0004);
		clk(2);
		chk("irq cleared", irq, 32'h0);
		rdchk(A_IS, 32'h0000_0000, "status cleared");
		apb(1'b1, A_IM, 32'h0000_0000);
		apb(1'b1, A_CL, 32'h0000_0080);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk(20);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_shutdown();
		t_flags();
		t_pin_mask();
		t_irq();
		finish_test();
	end

endmodule // fwsm_tb_top
